// file: rtl/pmd_defines.vh
// Operation
// R1: Software forces LED outputs via LED control register; reads return register, not pins.
// R2: Half duplex: carrier sense follows transmit or receive activity.
// R3: Full duplex: no collision reporting, carrier sense follows receive only.
// R4: Duplex chosen by bit 8 of basic mode control at 00h.
// R5: Fiber strap: duplex bit loads from duplex strap, negotiation straps ignored. Code loads duplex from negotiation strap zero.
// R6: No auto-negotiation while in fiber mode.
// R7: Parallel detection settles on half duplex.
// R8: Loopback bit 14 routes MII transmit to receive, nothing to media.
// R9: Loopback state shown in phy status bit 3.
// R10: Software disables negotiation before enabling loopback.
// R11: Shared pin is power-down input until interrupt output enable bit 0 set.
// R12: Pin low as input powers down like control bit 11.
// R13: Registers stay accessible in power-down; output enable releases pin input.
// R14: Interrupts off at reset; need global enable bit 1 and mask bits.
// R15: Interrupt pin driven low as soon as enabled condition occurs.
// R16: Status upper byte shows pending sources; any read clears all, releases pin.
// R17: Energy and link change mask bits together equal 0060h.
// R18: Energy detect keeps device low power when idle, pulses, wakes on activity.
// R19: Page select at 13h maps diagnostic page 2.
// R20: Reversed polarity flagged in phy status bit 12 and 10BASE-T status bit 4.
// R21: Polarity valid only at 10 Mb/s or negotiated 100 Mb/s.
// R22: Crossover state in phy status bit 14.
`ifndef PMD_DEFINES_VH
`define PMD_DEFINES_VH
`define PMD_OFS_BMC      8'h00
`define PMD_OFS_PHY_STATUS   8'h10
`define PMD_OFS_ICTL     8'h11
`define PMD_OFS_ISTAT    8'h12
`define PMD_OFS_PAGE     8'h13
`define PMD_OFS_LEN      8'h14
`define PMD_OFS_LED      8'h18
`define PMD_OFS_TBT      8'h1a
`define PMD_OFS_EDC      8'h1d
`define PMD_BMC_DUPLEX   8
`define PMD_BMC_PWRDN    11
`define PMD_BMC_ANEN     12
`define PMD_BMC_LOOP     14
`define PMD_STS_LINK     0
`define PMD_STS_SPEED10  1
`define PMD_STS_DUPLEX   2
`define PMD_STS_LOOP     3
`define PMD_STS_POL      12
`define PMD_STS_MDIX     14
`define PMD_ICTL_OE      0
`define PMD_ICTL_EN      1
`define PMD_ISTAT_ED     5
`define PMD_ISTAT_LINK   6
`define PMD_ISTAT_MASKS  8'h60
`define PMD_TBT_POL      4
`define PMD_EDC_EN       15
`define PMD_BMC_RST      16'h1000
`define PMD_DIAG_PAGE    16'h0002
`define PMD_ED_PULSE_US  1000
`define PMD_ED_PULSE_CYC (`PMD_ED_PULSE_US * 100)
`endif

// file: rtl/pmd_ctrl.v
`timescale 1ns/10ps
`include "pmd_defines.vh"
module pmd_ctrl #(
  parameter ED_PULSE_CYC = `PMD_ED_PULSE_CYC
) (
  // Clock and reset
  input  wire        CLK_SYS_IN,
  input  wire        SRST_IN,
  // AXI4-Lite write
  input  wire [7:0]  S_AXI_AWADDR_IN,
  input  wire        S_AXI_AWVALID_IN,
  output reg         S_AXI_AWREADY_OUT,
  input  wire [31:0] S_AXI_WDATA_IN,
  input  wire [3:0]  S_AXI_WSTRB_IN,
  input  wire        S_AXI_WVALID_IN,
  output reg         S_AXI_WREADY_OUT,
  output reg  [1:0]  S_AXI_BRESP_OUT,
  output reg         S_AXI_BVALID_OUT,
  input  wire        S_AXI_BREADY_IN,
  // AXI4-Lite read
  input  wire [7:0]  S_AXI_ARADDR_IN,
  input  wire        S_AXI_ARVALID_IN,
  output reg         S_AXI_ARREADY_OUT,
  output reg  [31:0] S_AXI_RDATA_OUT,
  output reg  [1:0]  S_AXI_RRESP_OUT,
  output reg         S_AXI_RVALID_OUT,
  input  wire        S_AXI_RREADY_IN,
  // MII
  input  wire        MII_TX_EN_IN,
  input  wire [3:0]  MII_TXD_IN,
  output reg         MII_RX_DV_OUT,
  output reg  [3:0]  MII_RXD_OUT,
  output reg         MII_CRS_OUT,
  output reg         MII_COL_OUT,
  // Media side
  input  wire        LINE_RX_DV_IN,
  input  wire [3:0]  LINE_RXD_IN,
  output reg         LINE_TX_EN_OUT,
  output reg  [3:0]  LINE_TXD_OUT,
  // Line status from the analog path
  input  wire        LINK_UP_IN,
  input  wire        SPEED_100_IN,
  input  wire        NEG_DONE_IN,
  input  wire        PAR_DETECT_IN,
  input  wire        POL_REV_IN,
  input  wire        MDIX_IN,
  input  wire        ENERGY_IN,
  input  wire [15:0] CABLE_LEN_IN,
  // Straps
  input  wire        FX_STRAP_IN,
  input  wire        NEGOTIATION_STRAP_ZERO_IN,
  input  wire        NEGOTIATION_STRAP_ONE_IN,
  input  wire        NEGOTIATION_ENABLE_STRAP_IN,
  // Shared power-down / interrupt pin
  input  wire        POWERDOWN_IRQ_PIN_IN,
  output reg         POWERDOWN_IRQ_PIN_OUT,
  output reg         POWERDOWN_IRQ_PIN_OE_OUT,
  // Power state and LEDs
  output reg         POWERED_DOWN_OUT,
  output reg         LOW_POWER_OUT,
  output reg         ED_PULSE_OUT,
  output reg  [2:0]  LED_OUT
);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  // MII transmit enable shares our clock, so it skips the synchronisers
  localparam NSYNC = 10;
  wire [NSYNC-1:0] async_in = {POWERDOWN_IRQ_PIN_IN, LINK_UP_IN, SPEED_100_IN, NEG_DONE_IN,
                               PAR_DETECT_IN, POL_REV_IN, MDIX_IN, ENERGY_IN,
                               FX_STRAP_IN, NEGOTIATION_STRAP_ZERO_IN};
  reg  [NSYNC-1:0] s1_q;
  reg  [NSYNC-1:0] s2_q;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge CLK_SYS_IN) begin
        s1_q[gi] <= async_in[gi];
        s2_q[gi] <= s1_q[gi];
      end
    end
  endgenerate
  wire pin_s    = s2_q[9];
  wire link_s   = s2_q[8];
  wire spd100_s = s2_q[7];
  wire negd_s   = s2_q[6];
  wire pard_s   = s2_q[5];
  wire pol_s    = s2_q[4];
  wire mdix_s   = s2_q[3];
  wire energy_s = s2_q[2];
  wire fx_s     = s2_q[1];
  wire an0_s    = s2_q[0];

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [15:0] bmc_q;
  reg [15:0] ictl_q;
  reg [7:0]  imask_q;
  reg [7:0]  ipend_q;
  reg [15:0] page_q;
  reg [15:0] led_q;
  reg [15:0] tbt_q;
  reg [15:0] edc_q;
  reg        strap_done_q;
  reg        fx_q;
  reg        link_prev_q;
  reg        lowp_prev_q;
  reg [31:0] ed_cnt_q;

  wire full_dup  = bmc_q[`PMD_BMC_DUPLEX];                   // R4
  wire loopback  = bmc_q[`PMD_BMC_LOOP];
  wire pin_is_in = ~ictl_q[`PMD_ICTL_OE];                    // R11
  wire pwrdn     = bmc_q[`PMD_BMC_PWRDN] | (pin_is_in & ~pin_s); // R12 R13
  wire lowp      = edc_q[`PMD_EDC_EN] & ~energy_s & ~link_s; // R18
  // Parallel detect ends half duplex; fiber never negotiates
  wire eff_dup   = full_dup & ~(pard_s & bmc_q[`PMD_BMC_ANEN] & ~fx_q); // R7 R6
  wire pol_ok    = ~spd100_s | (negd_s & ~pard_s & bmc_q[`PMD_BMC_ANEN] & ~fx_q); // R21
  wire pol_flag  = pol_s & pol_ok;                           // R20

  // Unlisted status bits read as zero
  reg [15:0] phy_status;
  always @* begin
    phy_status                   = 16'h0000;
    phy_status[`PMD_STS_LINK]    = link_s;
    phy_status[`PMD_STS_SPEED10] = ~spd100_s;
    phy_status[`PMD_STS_DUPLEX]  = eff_dup;                      // R7
    phy_status[`PMD_STS_LOOP]    = loopback;                     // R9
    phy_status[`PMD_STS_POL]     = pol_flag;                     // R20
    phy_status[`PMD_STS_MDIX]    = mdix_s;                       // R22
  end

  // Events: link change and energy-detect power state change
  reg [7:0] ev;
  always @* begin
    ev                  = 8'h00;
    ev[`PMD_ISTAT_ED]   = lowp ^ lowp_prev_q;
    ev[`PMD_ISTAT_LINK] = link_s ^ link_prev_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  reg        aw_ok_q;
  reg [7:0]  awaddr_q;
  reg        w_ok_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  wire       do_wr = aw_ok_q & w_ok_q & ~S_AXI_BVALID_OUT;
  wire       do_rd = S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT;
  // Word index: byte address over four
  wire [7:0] wi    = {2'b00, awaddr_q[7:2]};
  wire [7:0] ri    = {2'b00, S_AXI_ARADDR_IN[7:2]};
  wire [15:0] wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire        diag  = (page_q == `PMD_DIAG_PAGE);            // R19

  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [15:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  reg [15:0] rd_val;
  reg        rd_hit;
  always @* begin
    rd_val = 16'h0000;
    rd_hit = 1'b1;
    case (ri)
      `PMD_OFS_BMC:    rd_val = bmc_q;
      `PMD_OFS_PHY_STATUS: rd_val = phy_status;
      `PMD_OFS_ICTL:   rd_val = ictl_q;
      `PMD_OFS_ISTAT:  rd_val = {ipend_q, imask_q};          // R16
      `PMD_OFS_PAGE:   rd_val = page_q;
      `PMD_OFS_LEN:    rd_val = diag ? CABLE_LEN_IN : 16'h0000; // R19
      `PMD_OFS_LED:    rd_val = led_q;                       // R1
      `PMD_OFS_TBT:    rd_val = {tbt_q[15:5], pol_flag, tbt_q[3:0]}; // R20
      `PMD_OFS_EDC:    rd_val = edc_q;
      default:         rd_hit = 1'b0;
    endcase
  end

  // Unmapped offsets answer writes with a slave error
  reg wr_hit;
  always @* begin
    wr_hit = 1'b0;
    case (wi)
      `PMD_OFS_BMC,
      `PMD_OFS_ICTL,
      `PMD_OFS_ISTAT,
      `PMD_OFS_PAGE,
      `PMD_OFS_LED,
      `PMD_OFS_TBT,
      `PMD_OFS_EDC: wr_hit = 1'b1;
      default:      wr_hit = 1'b0;
    endcase
  end

  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      S_AXI_AWREADY_OUT <= 1'b0;
      S_AXI_WREADY_OUT  <= 1'b0;
      S_AXI_BVALID_OUT  <= 1'b0;
      S_AXI_BRESP_OUT   <= 2'h0;
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT  <= 1'b0;
      S_AXI_RDATA_OUT   <= 32'h0000_0000;
      S_AXI_RRESP_OUT   <= 2'h0;
      aw_ok_q  <= 1'b0;
      w_ok_q   <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      S_AXI_AWREADY_OUT <= ~aw_ok_q & ~S_AXI_AWREADY_OUT & S_AXI_AWVALID_IN;
      S_AXI_WREADY_OUT  <= ~w_ok_q & ~S_AXI_WREADY_OUT & S_AXI_WVALID_IN;
      if (S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT) begin
        aw_ok_q  <= 1'b1;
        awaddr_q <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN & S_AXI_WREADY_OUT) begin
        w_ok_q  <= 1'b1;
        wdata_q <= S_AXI_WDATA_IN;
        wstrb_q <= S_AXI_WSTRB_IN;
      end
      if (do_wr) begin
        aw_ok_q          <= 1'b0;
        w_ok_q           <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT  <= wr_hit ? 2'h0 : 2'h2;
      end else if (S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT <= 1'b0;
      end
      S_AXI_ARREADY_OUT <= ~S_AXI_ARREADY_OUT & ~S_AXI_RVALID_OUT & S_AXI_ARVALID_IN;
      if (do_rd) begin
        S_AXI_RVALID_OUT <= 1'b1;
        S_AXI_RDATA_OUT  <= {16'h0000, rd_val};
        S_AXI_RRESP_OUT  <= rd_hit ? 2'h0 : 2'h2;
      end else if (S_AXI_RREADY_IN) begin
        S_AXI_RVALID_OUT <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file
  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      bmc_q        <= `PMD_BMC_RST;
      ictl_q       <= 16'h0000;
      imask_q      <= 8'h00;                                 // R14
      page_q       <= 16'h0000;
      led_q        <= 16'h0000;
      tbt_q        <= 16'h0000;
      edc_q        <= 16'h0000;
      strap_done_q <= 1'b0;
      fx_q         <= 1'b0;
    end else begin
      // Straps caught once after reset release, past the synchronisers
      if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        fx_q         <= fx_s;
        if (fx_s) begin
          bmc_q[`PMD_BMC_DUPLEX] <= an0_s;                   // R5
          bmc_q[`PMD_BMC_ANEN]   <= 1'b0;                    // R6
        end
      end
      if (do_wr) begin
        case (wi)
          `PMD_OFS_BMC: begin
            bmc_q <= merge(bmc_q, wdata_q[15:0], wmask);
            if (fx_q) begin
              bmc_q[`PMD_BMC_ANEN] <= 1'b0;                  // R6
            end
          end
          `PMD_OFS_ICTL:  ictl_q  <= merge(ictl_q, wdata_q[15:0], wmask & 16'h0003);
          `PMD_OFS_ISTAT: begin
            // Pending byte is read-only; only two mask bits exist
            if (wstrb_q[0]) begin
              imask_q <= wdata_q[7:0] & `PMD_ISTAT_MASKS;    // R17
            end
          end
          `PMD_OFS_PAGE:  page_q  <= merge(page_q, wdata_q[15:0], wmask);
          `PMD_OFS_LED:   led_q   <= merge(led_q, wdata_q[15:0], wmask); // R1
          `PMD_OFS_TBT:   tbt_q   <= merge(tbt_q, wdata_q[15:0], wmask & 16'hffef);
          `PMD_OFS_EDC:   edc_q   <= merge(edc_q, wdata_q[15:0], wmask);
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt pending flags
  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      ipend_q     <= 8'h00;
      link_prev_q <= 1'b0;
      lowp_prev_q <= 1'b0;
    end else begin
      link_prev_q <= link_s;
      lowp_prev_q <= lowp;
      // New events win over the clear-on-read, so none is lost
      if (do_rd && ri == `PMD_OFS_ISTAT) begin
        ipend_q <= ev & imask_q;                             // R16
      end else begin
        ipend_q <= ipend_q | (ev & imask_q);                 // R14
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Energy-detect pulse timer, power state and pin outputs
  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      ed_cnt_q                 <= 32'h0000_0000;
      ED_PULSE_OUT             <= 1'b0;
      LOW_POWER_OUT            <= 1'b0;
      POWERED_DOWN_OUT         <= 1'b0;
      POWERDOWN_IRQ_PIN_OUT    <= 1'b1;
      POWERDOWN_IRQ_PIN_OE_OUT <= 1'b0;
      LED_OUT                  <= 3'h0;
    end else begin
      // Occasional pulse on the line while idle
      ED_PULSE_OUT <= 1'b0;
      if (!lowp) begin
        ed_cnt_q <= 32'h0000_0000;
      end else if (ed_cnt_q >= ED_PULSE_CYC - 1) begin
        ed_cnt_q     <= 32'h0000_0000;
        ED_PULSE_OUT <= 1'b1;                                // R18
      end else begin
        ed_cnt_q <= ed_cnt_q + 32'h0000_0001;
      end
      LOW_POWER_OUT    <= lowp;                              // R18
      POWERED_DOWN_OUT <= pwrdn;                             // R12
      // Pending set drives low at once; one cycle of register latency only
      POWERDOWN_IRQ_PIN_OE_OUT <= ictl_q[`PMD_ICTL_OE];       // R11
      POWERDOWN_IRQ_PIN_OUT    <= ~(ictl_q[`PMD_ICTL_EN] &
                                    (|(ipend_q | (ev & imask_q)))); // R15 R14
      LED_OUT <= led_q[2:0];                                 // R1
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // MII and media data path
  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      MII_RX_DV_OUT  <= 1'b0;
      MII_RXD_OUT    <= 4'h0;
      MII_CRS_OUT    <= 1'b0;
      MII_COL_OUT    <= 1'b0;
      LINE_TX_EN_OUT <= 1'b0;
      LINE_TXD_OUT   <= 4'h0;
    end else begin
      // Power-down silences the line; loopback stays usable for tests
      if (loopback) begin
        MII_RX_DV_OUT  <= MII_TX_EN_IN;                      // R8
        MII_RXD_OUT    <= MII_TXD_IN;
        LINE_TX_EN_OUT <= 1'b0;
        LINE_TXD_OUT   <= 4'h0;
      end else begin
        MII_RX_DV_OUT  <= LINE_RX_DV_IN & ~pwrdn;
        MII_RXD_OUT    <= LINE_RXD_IN;
        LINE_TX_EN_OUT <= MII_TX_EN_IN & ~pwrdn;
        LINE_TXD_OUT   <= MII_TXD_IN;
      end
      MII_CRS_OUT <= eff_dup ? LINE_RX_DV_IN                 // R3
                             : (LINE_RX_DV_IN | MII_TX_EN_IN); // R2
      MII_COL_OUT <= ~eff_dup & ~loopback & LINE_RX_DV_IN & MII_TX_EN_IN; // R3
    end
  end

endmodule

// file: tb/pmd_mac_model.sv
`timescale 1ns/10ps
module pmd_mac_model (
  // Clock
  input  wire logic       clk_in,
  // Bench request
  input  wire logic       send_in,
  input  wire logic [3:0] nib_in,
  // MII transmit
  output logic            tx_en_out,
  output logic [3:0]      txd_out
);
  initial begin
    tx_en_out = 1'h0;
    txd_out   = 4'h0;
  end
  // Idle nibbles toggle so stale data never passes for a frame
  always @(posedge clk_in) begin
    tx_en_out <= send_in;
    txd_out   <= send_in ? nib_in : ~txd_out;
  end
endmodule

// file: tb/pmd_ctrl_sva.sv
`timescale 1ns/10ps
module pmd_ctrl_sva #(
  parameter ED_PULSE_CYC = 16
) (
  // Clock and reset
  input wire       CLK_SYS_IN,
  input wire       SRST_IN,
  // Register bus
  input wire [7:0] S_AXI_ARADDR_IN,
  input wire       S_AXI_ARVALID_IN,
  input wire       S_AXI_ARREADY_OUT,
  input wire       S_AXI_RVALID_OUT,
  input wire       S_AXI_BVALID_OUT,
  input wire       S_AXI_BREADY_IN,
  // MII and media
  input wire       MII_TX_EN_IN,
  input wire       LINE_RX_DV_IN,
  input wire       MII_CRS_OUT,
  input wire       MII_COL_OUT,
  input wire       LINE_TX_EN_OUT,
  // Pin and power
  input wire       POWERDOWN_IRQ_PIN_OUT,
  input wire       POWERDOWN_IRQ_PIN_OE_OUT,
  input wire       POWERED_DOWN_OUT,
  input wire       LOW_POWER_OUT,
  input wire       ED_PULSE_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SRST_IN);
  ////////////////////////////////////////
  // Cycles since last energy pulse in low power
  logic [15:0] gap_q;
  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN || !LOW_POWER_OUT || ED_PULSE_OUT) gap_q <= 16'h0;
    else gap_q <= gap_q + 16'h1;
  end
  ////////////////////////////////////////
  property p_crs; MII_CRS_OUT |-> $past(MII_TX_EN_IN || LINE_RX_DV_IN); endproperty
  a_crs: assert property (p_crs) else $error("crs without activity");
  property p_col; MII_COL_OUT |-> $past(MII_TX_EN_IN && LINE_RX_DV_IN); endproperty
  a_col: assert property (p_col) else $error("col without both");
  property p_ltx; LINE_TX_EN_OUT |-> $past(MII_TX_EN_IN); endproperty
  a_ltx: assert property (p_ltx) else $error("line tx without mii tx");
  property p_pdq; POWERED_DOWN_OUT && $past(POWERED_DOWN_OUT) |-> !LINE_TX_EN_OUT; endproperty
  a_pdq: assert property (p_pdq) else $error("tx in power down");
  property p_oe; !POWERDOWN_IRQ_PIN_OUT |-> POWERDOWN_IRQ_PIN_OE_OUT; endproperty
  a_oe: assert property (p_oe) else $error("irq low while input");
  property p_clr;
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT && S_AXI_ARADDR_IN == 8'h48
      |-> ##[1:3] POWERDOWN_IRQ_PIN_OUT;
  endproperty
  a_clr: assert property (p_clr) else $error("pin held after status read");
  property p_ed; ED_PULSE_OUT |-> LOW_POWER_OUT ##1 !ED_PULSE_OUT; endproperty
  a_ed: assert property (p_ed) else $error("bad energy pulse");
  property p_gap; LOW_POWER_OUT |-> gap_q <= ED_PULSE_CYC + 2; endproperty
  a_gap: assert property (p_gap) else $error("energy pulse missing");
  property p_bhold; S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rans; S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |-> ##[1:2] S_AXI_RVALID_OUT; endproperty
  a_rans: assert property (p_rans) else $error("read not answered");
  c_col: cover property (MII_COL_OUT);
  c_irq: cover property (!POWERDOWN_IRQ_PIN_OUT);
  c_ed: cover property (ED_PULSE_OUT);
endmodule
bind pmd_ctrl pmd_ctrl_sva #(.ED_PULSE_CYC(ED_PULSE_CYC)) pmd_ctrl_sva_i (.*);

// file: tb/pmd_ctrl_tb.sv
`timescale 1ns/10ps
`include "pmd_defines.vh"
module pmd_ctrl_tb;
  logic        CLK_SYS_IN = 1'h0, SRST_IN = 1'h1, pd_n = 1'h1, send = 1'h0;
  logic [7:0]  S_AXI_AWADDR_IN = 8'h00, S_AXI_ARADDR_IN = 8'h00;
  logic [31:0] S_AXI_WDATA_IN = 32'h0, rdv;
  logic [3:0]  S_AXI_WSTRB_IN = 4'hf, LINE_RXD_IN = 4'h9, nib = 4'h5;
  logic [15:0] CABLE_LEN_IN = 16'h1234;
  logic        S_AXI_AWVALID_IN = 1'h0, S_AXI_WVALID_IN = 1'h0, S_AXI_BREADY_IN = 1'h0;
  logic        S_AXI_ARVALID_IN = 1'h0, S_AXI_RREADY_IN = 1'h0, LINE_RX_DV_IN = 1'h0;
  logic        LINK_UP_IN = 1'h0, SPEED_100_IN = 1'h0, NEG_DONE_IN = 1'h0, PAR_DETECT_IN = 1'h0;
  logic        POL_REV_IN = 1'h0, MDIX_IN = 1'h0, ENERGY_IN = 1'h0, FX_STRAP_IN = 1'h0;
  logic        NEGOTIATION_STRAP_ZERO_IN = 1'h0, NEGOTIATION_STRAP_ONE_IN = 1'h0;
  logic        NEGOTIATION_ENABLE_STRAP_IN = 1'h0;
  wire         S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT;
  wire         S_AXI_RVALID_OUT, MII_TX_EN_IN, MII_RX_DV_OUT, MII_CRS_OUT, MII_COL_OUT;
  wire         LINE_TX_EN_OUT, POWERDOWN_IRQ_PIN_IN, POWERDOWN_IRQ_PIN_OUT, ED_PULSE_OUT;
  wire         POWERDOWN_IRQ_PIN_OE_OUT, POWERED_DOWN_OUT, LOW_POWER_OUT;
  wire [1:0]   S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
  wire [31:0]  S_AXI_RDATA_OUT;
  wire [3:0]   MII_TXD_IN, MII_RXD_OUT, LINE_TXD_OUT;
  wire [2:0]   LED_OUT;
  int          num_errors = 0, n_compared = 0, np;
  // Bench level pd_n on the shared pin unless the design drives it
  assign POWERDOWN_IRQ_PIN_IN = POWERDOWN_IRQ_PIN_OE_OUT ? POWERDOWN_IRQ_PIN_OUT : pd_n;
  pmd_ctrl #(.ED_PULSE_CYC(16)) pmd_ctrl_i (.*);
  pmd_mac_model pmd_mac_model_i (.clk_in(CLK_SYS_IN), .send_in(send), .nib_in(nib),
    .tx_en_out(MII_TX_EN_IN), .txd_out(MII_TXD_IN));
  initial begin
    forever #5 CLK_SYS_IN = ~CLK_SYS_IN;
  end
  ////////////////////////////////////////
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    n_compared++;
    if (s !== e) begin
      $display("[FAIL] %s exp %h got %h", nm, e, s);
      num_errors++;
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 50) begin
      num_errors++;
      end_sim;
    end
  endtask
  task automatic wr(input logic [7:0] ix, input logic [15:0] d);
    int n;
    n = 0;
    S_AXI_AWADDR_IN <= {ix[5:0], 2'h0};
    S_AXI_WDATA_IN <= {16'h0, d};
    S_AXI_AWVALID_IN <= 1'h1;
    S_AXI_WVALID_IN <= 1'h1;
    do begin
      @(posedge CLK_SYS_IN);
      n++;
      if (S_AXI_AWREADY_OUT) S_AXI_AWVALID_IN <= 1'h0;
      if (S_AXI_WREADY_OUT) S_AXI_WVALID_IN <= 1'h0;
      if (!S_AXI_AWVALID_IN && !S_AXI_WVALID_IN) S_AXI_BREADY_IN <= 1'h1;
    end while (!(S_AXI_BVALID_OUT && S_AXI_BREADY_IN) && n < 50);
    S_AXI_BREADY_IN <= 1'h0;
    tmo(n);
    chk(S_AXI_BRESP_OUT, 2'h0, "bresp");
  endtask
  task automatic rd(input logic [7:0] ix, input logic [1:0] er);
    int n;
    n = 0;
    S_AXI_ARADDR_IN <= {ix[5:0], 2'h0};
    S_AXI_ARVALID_IN <= 1'h1;
    do begin
      @(posedge CLK_SYS_IN);
      n++;
      if (S_AXI_ARREADY_OUT) S_AXI_ARVALID_IN <= 1'h0;
      if (!S_AXI_ARVALID_IN) S_AXI_RREADY_IN <= 1'h1;
    end while (!(S_AXI_RVALID_OUT && S_AXI_RREADY_IN) && n < 50);
    rdv = S_AXI_RDATA_OUT;
    S_AXI_RREADY_IN <= 1'h0;
    tmo(n);
    chk(S_AXI_RRESP_OUT, er, "rresp");
  endtask
  // Waits cover the MAC register plus the design's output register
  task automatic mii(input logic t, input logic r);
    send <= t;
    LINE_RX_DV_IN <= r;
    repeat (4) @(posedge CLK_SYS_IN);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge CLK_SYS_IN);
    SRST_IN <= 1'h0;
    rd(`PMD_OFS_BMC, 2'h0);
    chk(rdv, 32'h1000, "bmc reset");
    wr(`PMD_OFS_LED, 16'h0005);
    rd(`PMD_OFS_LED, 2'h0);
    chk(rdv, 32'h5, "led reg");
    chk(LED_OUT, 3'h5, "led pins");
    rd(8'h01, 2'h2);
    mii(1'h1, 1'h0);
    chk(MII_CRS_OUT, 1'h1, "crs half tx");
    chk({LINE_TX_EN_OUT, LINE_TXD_OUT}, 5'h15, "line tx");
    mii(1'h1, 1'h1);
    chk(MII_COL_OUT, 1'h1, "col half");
    mii(1'h0, 1'h0);
    wr(`PMD_OFS_BMC, 16'h0100);
    mii(1'h1, 1'h0);
    chk(MII_CRS_OUT, 1'h0, "crs full tx");
    mii(1'h0, 1'h1);
    chk(MII_CRS_OUT, 1'h1, "crs full rx");
    mii(1'h1, 1'h1);
    chk(MII_COL_OUT, 1'h0, "col full");
    wr(`PMD_OFS_BMC, 16'h1100);
    PAR_DETECT_IN <= 1'h1;
    mii(1'h1, 1'h0);
    mii(1'h1, 1'h0);
    chk(MII_CRS_OUT, 1'h1, "crs parallel");
    PAR_DETECT_IN <= 1'h0;
    mii(1'h0, 1'h0);
    wr(`PMD_OFS_BMC, 16'h4100);
    mii(1'h1, 1'h0);
    chk({MII_RX_DV_OUT, MII_RXD_OUT, LINE_TX_EN_OUT}, 6'h2a, "loopback");
    rd(`PMD_OFS_PHY_STATUS, 2'h0);
    chk(rdv[`PMD_STS_LOOP], 1'h1, "loop flag");
    mii(1'h0, 1'h0);
    wr(`PMD_OFS_BMC, 16'h0100);
    rd(`PMD_OFS_PHY_STATUS, 2'h0);
    chk(rdv[`PMD_STS_LOOP], 1'h0, "loop flag off");
    wr(`PMD_OFS_ISTAT, 16'hffff);
    rd(`PMD_OFS_ISTAT, 2'h0);
    chk(rdv[7:0], 8'h60, "mask bits");
    LINK_UP_IN <= 1'h1;
    repeat (6) @(posedge CLK_SYS_IN);
    chk({POWERDOWN_IRQ_PIN_OE_OUT, POWERDOWN_IRQ_PIN_OUT}, 2'h1, "pin idle");
    rd(`PMD_OFS_ISTAT, 2'h0);
    wr(`PMD_OFS_ICTL, 16'h0003);
    @(posedge CLK_SYS_IN);
    chk(POWERDOWN_IRQ_PIN_OE_OUT, 1'h1, "pin output");
    LINK_UP_IN <= 1'h0;
    repeat (6) @(posedge CLK_SYS_IN);
    chk(POWERDOWN_IRQ_PIN_OUT, 1'h0, "irq low");
    rd(`PMD_OFS_ISTAT, 2'h0);
    chk(rdv[14], 1'h1, "link pending");
    repeat (3) @(posedge CLK_SYS_IN);
    chk(POWERDOWN_IRQ_PIN_OUT, 1'h1, "irq released");
    wr(`PMD_OFS_ICTL, 16'h0000);
    pd_n <= 1'h0;
    repeat (6) @(posedge CLK_SYS_IN);
    chk(POWERED_DOWN_OUT, 1'h1, "pin power down");
    rd(`PMD_OFS_BMC, 2'h0);
    mii(1'h1, 1'h0);
    chk(LINE_TX_EN_OUT, 1'h0, "no tx in power down");
    mii(1'h0, 1'h0);
    wr(`PMD_OFS_ICTL, 16'h0001);
    repeat (6) @(posedge CLK_SYS_IN);
    chk(POWERED_DOWN_OUT, 1'h0, "pin released");
    pd_n <= 1'h1;
    wr(`PMD_OFS_BMC, 16'h0900);
    repeat (2) @(posedge CLK_SYS_IN);
    chk(POWERED_DOWN_OUT, 1'h1, "bit power down");
    wr(`PMD_OFS_BMC, 16'h0100);
    wr(`PMD_OFS_EDC, 16'h8000);
    np = 0;
    repeat (40) begin
      @(posedge CLK_SYS_IN);
      np = np + ED_PULSE_OUT;
    end
    chk({LOW_POWER_OUT, np > 1}, 2'h3, "energy idle");
    ENERGY_IN <= 1'h1;
    repeat (6) @(posedge CLK_SYS_IN);
    chk(LOW_POWER_OUT, 1'h0, "energy wake");
    POL_REV_IN <= 1'h1;
    MDIX_IN <= 1'h1;
    repeat (6) @(posedge CLK_SYS_IN);
    rd(`PMD_OFS_PHY_STATUS, 2'h0);
    chk({rdv[14], rdv[12]}, 2'h3, "mdix and polarity");
    rd(`PMD_OFS_TBT, 2'h0);
    chk(rdv[`PMD_TBT_POL], 1'h1, "ten polarity");
    SPEED_100_IN <= 1'h1;
    repeat (6) @(posedge CLK_SYS_IN);
    rd(`PMD_OFS_PHY_STATUS, 2'h0);
    chk(rdv[12], 1'h0, "forced 100 polarity");
    wr(`PMD_OFS_BMC, 16'h1100);
    NEG_DONE_IN <= 1'h1;
    repeat (6) @(posedge CLK_SYS_IN);
    rd(`PMD_OFS_PHY_STATUS, 2'h0);
    chk(rdv[12], 1'h1, "negotiated 100 polarity");
    wr(`PMD_OFS_PAGE, 16'h0002);
    rd(`PMD_OFS_LEN, 2'h0);
    chk(rdv, 32'h1234, "page two");
    wr(`PMD_OFS_PAGE, 16'h0000);
    rd(`PMD_OFS_LEN, 2'h0);
    chk(rdv, 32'h0, "page zero");
    {FX_STRAP_IN, NEGOTIATION_STRAP_ZERO_IN, NEGOTIATION_STRAP_ONE_IN} <= 3'h7;
    NEGOTIATION_ENABLE_STRAP_IN <= 1'h1;
    SRST_IN <= 1'h1;
    repeat (3) @(posedge CLK_SYS_IN);
    SRST_IN <= 1'h0;
    repeat (4) @(posedge CLK_SYS_IN);
    rd(`PMD_OFS_BMC, 2'h0);
    chk(rdv[`PMD_BMC_DUPLEX], 1'h1, "strap duplex");
    end_sim;
  end
endmodule
